// >>> rtl/dah_consts.vh
/*
 * Constants for the converter array host control block.
 * Assumes a single 40 MHz system clock; included by the design module.
 */
`ifndef DAH_CONSTS_VH
`define DAH_CONSTS_VH

// Channel space
`define DAH_ADDR_W 5
`define DAH_CH_W 6
`define DAH_CODE_W 14
`define DAH_NUM_CH 32
`define DAH_OFFS_CH 6'h20
`define DAH_CH_ALL 6'h3F

// Serial frame lengths in bits
`define DAH_DAC_BITS 5'h14
`define DAH_SHM_BITS 5'h06
`define DAH_SH_W 20

// Reset pulse window on the follow/clear input
`define DAH_CLK_NS 25
`define DAH_RST_MIN_NS 90
`define DAH_RST_MAX_NS 200

// Pin vector layout after synchronisation
`define DAH_PIN_W 14
`define DAH_P_PICK 13
`define DAH_P_MODE 12
`define DAH_P_SYNC 11
`define DAH_P_SCLK 10
`define DAH_P_DIN 9
`define DAH_P_WR 8
`define DAH_P_OFFS 7
`define DAH_P_ADDR_HI 6
`define DAH_P_ADDR_LO 2
`define DAH_P_CAL 1
`define DAH_P_TRK 0

// Idle level of each pin when left floating
`define DAH_PULL_DEFAULT 14'h0A7D

`endif

// >>> rtl/dah_ctrl.v
/*
 * Digital control of a 32-channel converter array with sample-and-hold
 * acquisition: serial/parallel host interface, channel registers,
 * acquisition sequencing and busy flag, reset by short low pulse.
 * Assumes all host pins are asynchronous to clk (40 MHz) and that the
 * acquired sample arrives as a digital code on analog_sample_input.
 */
`timescale 1ns/100ps
`include "dah_consts.vh"

// Overview of operation
// (R1) Low on interface_pick selects the parallel port, high the serial one.
// (R2) Undriven pins read as their pull level: address, din, follow high.
// (R3) Parallel access picks one of 32 channels, top address pin as MSB.
// (R4) A parallel acquire-all request makes all 32 channels acquire at once.
// (R5) The active-low sync_n pin is chip select or serial frame by mode.
// (R6) A parallel access is wr_n low together with chip select low.
// (R7) offset_sel high redirects the parallel access to the offset channel.
// (R8) The host keeps sclk at or below 14 MHz, or 20 MHz in held mode.
// (R9) Serial input is sampled at each falling edge of sclk.
// (R10) Readback data changes on rising sclk and is captured on falling.
// (R11) busy_n is low while an acquisition runs and high when it is done.
// (R12) With follow_clear high, addressing a channel starts acquisition.
// (R13) With follow_clear low the channel follows; its rise starts acquiring.
// (R14) A low pulse of 90 to 200 ns on follow_clear resets the device.
// (R15) Reset clears every channel register, offset channel included.
// (R16) A converter-mode serial write loads 14 bits into the one channel.
// (R17) The low time of follow_clear is measured to tell reset from tracking.

module dah_ctrl #(
    parameter [15:0] ACQ_CYCLES = 16'h0028
)(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Mode selection
    input wire interface_pick,
    input wire held_sample_mode,
    // Serial port and shared select
    input wire sync_n,
    input wire sclk,
    input wire din,
    output reg dout,
    // Parallel port
    input wire wr_n,
    input wire offset_sel,
    input wire [4:0] channel_addr_pins,
    input wire acquire_all,
    // Acquisition control
    input wire follow_clear,
    input wire [13:0] analog_sample_input,
    output reg busy_n,
    output reg follow_active,
    output reg [5:0] follow_chan,
    // Register update report
    output reg load_strobe,
    output reg [5:0] load_chan,
    output reg [13:0] load_code,
    output reg dev_clear
);

    localparam integer RST_MIN =
        (`DAH_RST_MIN_NS + `DAH_CLK_NS - 1) / `DAH_CLK_NS;
    localparam integer RST_MAX = `DAH_RST_MAX_NS / `DAH_CLK_NS;
    localparam [7:0] RST_MIN_C = RST_MIN[7:0];
    localparam [7:0] RST_MAX_C = RST_MAX[7:0];
    localparam [7:0] LOW_SAT = 8'hFF;

    localparam ST_IDLE = 1'b0;
    localparam ST_ACQ = 1'b1;

    function [5:0] dah_chan_sel;
        input offs;
        input [4:0] addr;
        begin
            dah_chan_sel = offs ? `DAH_OFFS_CH : {1'b0, addr};
        end
    endfunction

    // Two-stage synchronisers; third stage only feeds edge detection
    reg [`DAH_PIN_W-1:0] pin_a;
    reg [`DAH_PIN_W-1:0] pin_b;
    reg [`DAH_PIN_W-1:0] pin_p;
    reg [13:0] smp_a;
    reg [13:0] smp_b;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_a <= `DAH_PULL_DEFAULT; // R2
            pin_b <= `DAH_PULL_DEFAULT; // R2
            pin_p <= `DAH_PULL_DEFAULT; // R2
            smp_a <= 14'h0000;
            smp_b <= 14'h0000;
        end
        else
        begin
            pin_a <= {interface_pick, held_sample_mode, sync_n, sclk, din,
                      wr_n, offset_sel, channel_addr_pins, acquire_all,
                      follow_clear};
            pin_b <= pin_a;
            pin_p <= pin_b;
            smp_a <= analog_sample_input;
            smp_b <= smp_a;
        end
    end

    wire ser_mode = pin_b[`DAH_P_PICK]; // R1
    wire shm_mode = pin_b[`DAH_P_MODE];
    wire sel_low = ~pin_b[`DAH_P_SYNC]; // R5
    wire frame_start = pin_p[`DAH_P_SYNC] & ~pin_b[`DAH_P_SYNC];
    wire frame_end = ~pin_p[`DAH_P_SYNC] & pin_b[`DAH_P_SYNC];
    wire sclk_fall = pin_p[`DAH_P_SCLK] & ~pin_b[`DAH_P_SCLK];
    wire sclk_rise = ~pin_p[`DAH_P_SCLK] & pin_b[`DAH_P_SCLK];
    wire strobe_now = sel_low & ~pin_b[`DAH_P_WR];
    wire strobe_old = ~pin_p[`DAH_P_SYNC] & ~pin_p[`DAH_P_WR];
    wire par_access = ~ser_mode & strobe_now & ~strobe_old; // R6
    wire cal_rise = ~ser_mode & pin_b[`DAH_P_CAL] & ~pin_p[`DAH_P_CAL];
    wire trk_high = pin_b[`DAH_P_TRK];
    wire trk_rise = pin_b[`DAH_P_TRK] & ~pin_p[`DAH_P_TRK];
    wire [5:0] par_chan = dah_chan_sel(pin_b[`DAH_P_OFFS],
        pin_b[`DAH_P_ADDR_HI:`DAH_P_ADDR_LO]); // R3 R7

    // Low-time measurement of the follow/clear input
    reg [7:0] low_cnt;
    wire rst_evt = trk_rise && low_cnt >= RST_MIN_C &&
        low_cnt <= RST_MAX_C; // R14 R17
    wire long_low = low_cnt > RST_MAX_C; // R17

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            low_cnt <= 8'h00;
            dev_clear <= 1'b0;
        end
        else
        begin
            dev_clear <= rst_evt; // R14
            if (trk_high)
                low_cnt <= 8'h00;
            else if (low_cnt != LOW_SAT)
                low_cnt <= low_cnt + 8'h01; // R17
        end
    end

    // Serial shift-in, sampled on falling sclk inside a frame
    reg [`DAH_SH_W-1:0] sh_in;
    reg [4:0] bit_cnt;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sh_in <= 20'h0_0000;
            bit_cnt <= 5'h00;
        end
        else if (dev_clear || frame_start)
        begin
            sh_in <= 20'h0_0000;
            bit_cnt <= 5'h00;
        end
        else if (ser_mode && sel_low && sclk_fall)
        begin
            sh_in <= {sh_in[`DAH_SH_W-2:0], pin_b[`DAH_P_DIN]}; // R9
            if (bit_cnt != 5'h1F)
                bit_cnt <= bit_cnt + 5'h01;
        end
    end

    wire ser_end = ser_mode & frame_end;
    wire dac_write = ser_end & ~shm_mode &
        (bit_cnt == `DAH_DAC_BITS); // R16
    wire [5:0] dac_chan = dah_chan_sel(sh_in[19], sh_in[18:14]);
    wire [13:0] dac_code = sh_in[13:0];
    wire ser_addr = ser_end & shm_mode & (bit_cnt == `DAH_SHM_BITS);
    wire [5:0] shm_chan = dah_chan_sel(sh_in[5], sh_in[4:0]);

    // A frame of the wrong length is dropped; it never half-loads a channel
    wire addr_evt = par_access | ser_addr;
    wire [5:0] addr_chan = ser_mode ? shm_chan : par_chan;

    // Acquisition sequencer
    reg state;
    reg [15:0] acq_cnt;
    reg [5:0] acq_chan;
    reg [5:0] last_chan;
    reg addr_valid;
    wire acq_done = (state == ST_ACQ) && (acq_cnt == 16'h0000);
    // Acquire-all wins over an address access in the same cycle
    wire addr_start = addr_evt & trk_high; // R12
    wire trk_start = trk_rise & long_low & addr_valid; // R13
    wire acq_start = cal_rise | addr_start | trk_start;
    wire [5:0] start_chan = cal_rise ? `DAH_CH_ALL :
        (addr_start ? addr_chan : last_chan); // R4

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_IDLE;
            acq_cnt <= 16'h0000;
            acq_chan <= 6'h00;
            busy_n <= 1'b1;
        end
        else if (dev_clear)
        begin
            state <= ST_IDLE;
            busy_n <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (acq_start)
                    begin
                        state <= ST_ACQ;
                        acq_chan <= start_chan;
                        acq_cnt <= ACQ_CYCLES;
                        busy_n <= 1'b0; // R11
                    end
                end
                ST_ACQ:
                begin
                    if (acq_done)
                    begin
                        state <= ST_IDLE;
                        busy_n <= 1'b1; // R11
                    end
                    else
                        acq_cnt <= acq_cnt - 16'h0001;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Last addressed channel; it follows once the low outlasts a reset
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            last_chan <= 6'h00;
            addr_valid <= 1'b0;
            follow_active <= 1'b0;
            follow_chan <= 6'h00;
        end
        else
        begin
            follow_active <= ~trk_high & long_low & addr_valid &
                ~dev_clear; // R13
            follow_chan <= last_chan;
            if (dev_clear)
            begin
                last_chan <= 6'h00;
                addr_valid <= 1'b0;
            end
            else if (addr_evt | dac_write)
            begin
                last_chan <= addr_evt ? addr_chan : dac_chan;
                addr_valid <= 1'b1;
            end
        end
    end

    // Channel registers; index 32 is the offset channel
    reg [13:0] chan_reg [0:`DAH_NUM_CH];
    integer i;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (i = 0; i <= `DAH_NUM_CH; i = i + 1)
                chan_reg[i] <= 14'h0000; // R15
        end
        else if (dev_clear)
        begin
            for (i = 0; i <= `DAH_NUM_CH; i = i + 1)
                chan_reg[i] <= 14'h0000; // R15
        end
        else if (dac_write)
            chan_reg[dac_chan] <= dac_code; // R16
        else if (acq_done)
        begin
            for (i = 0; i <= `DAH_NUM_CH; i = i + 1)
                if (acq_chan == i[5:0] ||
                    (acq_chan == `DAH_CH_ALL && i < `DAH_NUM_CH))
                    chan_reg[i] <= smp_b; // R4
        end
    end

    // Update report, one pulse per serial write or per completed acquisition
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            load_strobe <= 1'b0;
            load_chan <= 6'h00;
            load_code <= 14'h0000;
        end
        else
        begin
            load_strobe <= (dac_write | acq_done) & ~dev_clear;
            if (dac_write | acq_done)
            begin
                load_chan <= dac_write ? dac_chan : acq_chan;
                load_code <= dac_write ? dac_code : smp_b;
            end
        end
    end

    // Readback of the last addressed channel, MSB first
    reg [13:0] rb_shift;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rb_shift <= 14'h0000;
            dout <= 1'b0;
        end
        else if (dev_clear)
        begin
            rb_shift <= 14'h0000;
            dout <= 1'b0;
        end
        else if (ser_mode && frame_start)
            rb_shift <= chan_reg[last_chan];
        else if (ser_mode && sel_low && sclk_rise)
        begin
            dout <= rb_shift[13]; // R10
            rb_shift <= {rb_shift[12:0], 1'b0}; // R10
        end
    end

endmodule

// >>> sim/dah_ctrl_asserts.sv
/* Checker on the dah_ctrl ports.
   Assumes pins move away from the rising clk edge. */
`timescale 1ns/100ps
module dah_ctrl_asserts #(
    parameter [15:0] ACQ_CYCLES = 16'h0028
)(
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Host pins
    input wire interface_pick,
    input wire held_sample_mode,
    input wire sync_n,
    input wire sclk,
    input wire wr_n,
    input wire acquire_all,
    input wire follow_clear,
    // Outputs
    input wire dout,
    input wire busy_n,
    input wire load_strobe,
    input wire [5:0] load_chan,
    input wire dev_clear
);
    reg [15:0] low_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    always @(posedge clk or negedge nrst)
        if (!nrst)
            low_cnt <= 16'h0000;
        else if (busy_n)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    // A soft reset may cut an acquisition short
    busy_len_a: assert property ($rose(busy_n) && !$past(dev_clear)
        && !dev_clear |-> low_cnt == ACQ_CYCLES + 16'h0001)
        else $error("busy length wrong");
    busy_load_a: assert property ($rose(busy_n) && !$past(dev_clear)
        && !dev_clear |-> load_strobe) else $error("no load at end");
    quiet_busy_a: assert property (!busy_n |-> !load_strobe)
        else $error("load while busy");
    load_once_a: assert property (load_strobe |=> !load_strobe)
        else $error("load strobe too long");
    clear_all_a: assert property (dev_clear |=> !dev_clear ##1
        busy_n && !dout && !load_strobe) else $error("clear failed");
    par_start_a: assert property ($fell(sync_n | wr_n)
        && !interface_pick && follow_clear && busy_n && !acquire_all
        |-> ##[3:6] !busy_n) else $error("parallel access lost");
    ser_quiet_a: assert property ($fell(sync_n) && interface_pick
        && !held_sample_mode && busy_n |-> busy_n [*6])
        else $error("acquire in converter mode");
    ser_load_a: assert property (load_strobe && interface_pick
        && !held_sample_mode |-> $past(sync_n, 3))
        else $error("load inside frame");
    dout_edge_a: assert property ($changed(dout) && !dev_clear
        && !$past(dev_clear) |-> $past(sclk, 3) || $past(sclk, 4)
        || $past(sclk, 5)) else $error("dout moved without sclk");
    chan_ok_a: assert property (load_strobe |-> load_chan <= 6'h20
        || load_chan == 6'h3F) else $error("bad channel");
    cover property (!busy_n ##1 busy_n);
    cover property (load_strobe && interface_pick);
    cover property (dev_clear);
endmodule
bind dah_ctrl dah_ctrl_asserts #(.ACQ_CYCLES(ACQ_CYCLES)) dah_ctrl_asserts_i (
    .clk(clk), .nrst(nrst), .interface_pick(interface_pick),
    .held_sample_mode(held_sample_mode), .sync_n(sync_n), .sclk(sclk),
    .wr_n(wr_n), .acquire_all(acquire_all), .follow_clear(follow_clear),
    .dout(dout), .busy_n(busy_n), .load_strobe(load_strobe),
    .load_chan(load_chan), .dev_clear(dev_clear)
);

// >>> sim/dah_host.sv
/* Host model: frame, shift clock, data and readback capture.
   Assumes the bench calls one task at a time. */
`timescale 1ns/100ps
module dah_host (
    // Serial pins
    output reg sync_n,
    output reg sclk,
    output reg din,
    input wire dout
);
    reg [13:0] rb;
    integer i;
    initial
    begin
        sync_n = 1'b1;
        sclk = 1'b0;
        din = 1'b1;
        rb = 14'h0000;
    end
    task cs(input reg lvl);
        sync_n = lvl;
    endtask
    // Long high phase leaves room for the slow readback path
    task frame(input integer n, input reg [19:0] w);
    begin
        #13;
        sync_n = 1'b0;
        #90;
        for (i = n - 1; i >= 0; i = i - 1)
        begin
            sclk = 1'b1;
            din = w[i];
            #110;
            sclk = 1'b0;
            if (i >= n - 14)
                rb = {rb[12:0], dout};
            #90;
        end
        din = 1'b1;
        sync_n = 1'b1;
    end
    endtask
endmodule

// >>> sim/dah_ctrl_tb.sv
/* Self-checking bench for dah_ctrl with the host model.
   Assumes the acquisition count is shortened to 4. */
`timescale 1ns/100ps
module dah_ctrl_tb;
    reg clk, nrst, interface_pick, held_sample_mode, wr_n, offset_sel;
    reg acquire_all, follow_clear;
    reg [4:0] channel_addr_pins;
    reg [13:0] analog_sample_input, c1;
    wire sync_n, sclk, din, dout, busy_n, follow_active, load_strobe;
    wire dev_clear;
    wire [5:0] follow_chan, load_chan;
    wire [13:0] load_code;
    reg [19:0] exp_q[$];
    reg [31:0] rnd;
    integer n_mismatch, n_compared, cycles, i, cnt;

    dah_ctrl #(.ACQ_CYCLES(16'h0004)) dah_ctrl_i (
        .clk(clk), .nrst(nrst), .interface_pick(interface_pick),
        .held_sample_mode(held_sample_mode), .sync_n(sync_n),
        .sclk(sclk), .din(din), .dout(dout), .wr_n(wr_n),
        .offset_sel(offset_sel), .channel_addr_pins(channel_addr_pins),
        .acquire_all(acquire_all), .follow_clear(follow_clear),
        .analog_sample_input(analog_sample_input), .busy_n(busy_n),
        .follow_active(follow_active), .follow_chan(follow_chan),
        .load_strobe(load_strobe), .load_chan(load_chan),
        .load_code(load_code), .dev_clear(dev_clear)
    );
    dah_host dah_host_i (.sync_n(sync_n), .sclk(sclk), .din(din),
        .dout(dout));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task check(input reg [19:0] seen, input reg [19:0] want);
    begin
        n_compared = n_compared + 1;
        if (seen !== want)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t saw %h want %h", $time, seen, want);
        end
    end
    endtask

    task tally_and_finish;
    begin
        $display("compared %0d bad %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    // A load with no note left is compared against unknown
    always @(negedge clk)
        if (load_strobe === 1'b1)
            check({load_chan, load_code},
                exp_q.size() > 0 ? exp_q.pop_front() : 20'hx);

    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %0t timeout", $time);
            tally_and_finish;
        end
    end

    task settle;
    begin
        cnt = 0;
        while (cnt < 300 && (exp_q.size() > 0 || busy_n !== 1'b1))
        begin
            @(negedge clk);
            cnt = cnt + 1;
        end
        repeat (8) @(negedge clk);
        check({19'h0, exp_q.size() == 0}, 20'h1);
    end
    endtask

    task strobe(input reg offs, input reg [4:0] a);
    begin
        rnd = $urandom;
        analog_sample_input = rnd[13:0];
        offset_sel = offs;
        channel_addr_pins = a;
        exp_q.push_back({offs ? 6'h20 : {1'b0, a}, rnd[13:0]});
        dah_host_i.cs(1'b0);
        @(negedge clk);
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        dah_host_i.cs(1'b1);
    end
    endtask

    task ser(input integer n, input reg [19:0] w);
    begin
        dah_host_i.frame(n, w);
        settle;
    end
    endtask

    initial
    begin
        n_mismatch = 0;
        n_compared = 0;
        cycles = 0;
        nrst = 1'b0;
        interface_pick = 1'b0;
        held_sample_mode = 1'b0;
        wr_n = 1'b1;
        offset_sel = 1'b0;
        acquire_all = 1'b0;
        follow_clear = 1'b1;
        channel_addr_pins = 5'h1F;
        analog_sample_input = 14'h0000;
        rnd = $urandom(59401);
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        check({busy_n, load_strobe, dev_clear, dout}, 20'h8);
        for (i = 0; i < 4; i = i + 1)
        begin
            rnd = $urandom;
            strobe(i == 2, i == 0 ? 5'h00 : i == 1 ? 5'h1F : rnd[4:0]);
            settle;
        end
        rnd = $urandom;
        analog_sample_input = rnd[13:0];
        exp_q.push_back({6'h3F, rnd[13:0]});
        acquire_all = 1'b1;
        repeat (4) @(negedge clk);
        acquire_all = 1'b0;
        settle;
        follow_clear = 1'b0;
        strobe(1'b0, 5'h07);
        repeat (20) @(negedge clk);
        check({follow_active, follow_chan}, {13'h0, 7'h47});
        follow_clear = 1'b1;
        settle;
        $display("test parallel done");
        interface_pick = 1'b1;
        repeat (4) @(negedge clk);
        rnd = $urandom;
        c1 = rnd[13:0];
        exp_q.push_back({6'h05, c1});
        ser(20, {6'h05, c1});
        rnd = $urandom;
        exp_q.push_back({6'h20, rnd[13:0]});
        ser(20, {6'h20, rnd[13:0]});
        check(dah_host_i.rb, c1);
        ser(19, {6'h05, c1});
        check(dah_host_i.rb, rnd[13:0]);
        for (i = 2; i < 6; i = i + 3)
        begin
            follow_clear = 1'b0;
            repeat (i) @(negedge clk);
            follow_clear = 1'b1;
            cnt = 0;
            repeat (12)
            begin
                @(negedge clk);
                cnt = cnt + (dev_clear === 1'b1);
            end
            check(cnt, i == 5);
        end
        exp_q.push_back({6'h03, c1});
        ser(20, {6'h03, c1});
        check(dah_host_i.rb, 20'h0);
        held_sample_mode = 1'b1;
        repeat (4) @(negedge clk);
        rnd = $urandom;
        analog_sample_input = rnd[13:0];
        exp_q.push_back({6'h1F, rnd[13:0]});
        ser(6, 20'h1F);
        $display("test serial done");
        tally_and_finish;
    end
endmodule
